// ===== design/aux_io_cfg.svh
// constants for the auxiliary connector selector and low-bit injection
// assumes inclusion by bare name from design files
`ifndef AUX_IO_CFG_SVH
`define AUX_IO_CFG_SVH

`define ADDR_MODE        4'h0
`define ADDR_PARAM       4'h1
`define ADDR_LSB_SEL     4'h2
`define ADDR_STATUS      4'h3
`define ADDR_SW_ENABLE   4'h4

`define MODE_ACQ_IND     4'h0
`define MODE_TRIG_EN_IN  4'h1
`define MODE_DIV_CLK     4'h2
`define MODE_LEVEL_IN    4'hD
`define MODE_GP_OUT      4'hE

`define MODE_SW_TE_BIT   8
`define PARAM_RESET      32'h0000_0003
`define DIV_MIN          32'h0000_0003

`define LSB_ZERO                   2'h0
`define LOW_BIT_EXT_TRIGGER_STATE  2'h1
`define LSB_AUX2                   2'h2
`define LSB_AUX1                   2'h3

`define SLOPE_RISING     32'h0000_0001
`define SLOPE_FALLING    32'h0000_0002

`endif

// ===== design/aux_io_pkg.sv
// types for the auxiliary connector selector
// assumes aux_io_cfg.svh holds the numeric constants
package aux_io_pkg;
    typedef enum logic [2:0] {
        gate_idle  = 3'b001,
        gate_armed = 3'b010,
        gate_fill  = 3'b100
    } gate_state_t;

    typedef struct packed {
        logic        s1;
        logic        s2;
        logic        prev;
    } sync_state_t;
endpackage

// ===== design/aux_pin_sync.sv
// two-stage synchroniser with a registered edge detector on the clean stage
// assumes an asynchronous pin input and one core clock
`timescale 1ns/1ps
`default_nettype none
module aux_pin_sync (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    aux_io_pkg::sync_state_t st;
    aux_io_pkg::sync_state_t next_st;

    always_comb begin
        next_st      = st;
        next_st.s1   = pin;
        next_st.s2   = st.s1;
        next_st.prev = st.s2;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.s2;
    assign rise  = st.s2 & ~st.prev;
    assign fall  = ~st.s2 & st.prev;
endmodule
`default_nettype wire

// ===== design/aux_io_lsb.sv
// auxiliary connector function selector and sample low-bit injection
// assumes the sample clock as core_clk, acquisition reset as sys_rst,
// and an Avalon-MM master for the configuration registers
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`include "aux_io_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module aux_io_lsb #(
    parameter int SAMPLE_BITS = 14
) (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        aux_in,
    output logic             aux_out,
    output logic             aux_oe_n,
    input  wire logic        aux2_in,
    input  wire logic        ext_trig_in,
    input  wire logic        capture_active,
    input  wire logic        trigger_in,
    input  wire logic        buffer_done,
    output logic             trigger_accept,
    output logic             trigger_enable_event,
    input  wire logic [15:0] sample_in,
    input  wire logic        sample_valid,
    output logic      [15:0] sample_out,
    output logic             sample_out_valid
);
    if (SAMPLE_BITS != 12 && SAMPLE_BITS != 14) begin : g_bad_width
        $error("SAMPLE_BITS must be 12 or 14");
    end

    typedef struct packed {
        logic [3:0]               mode;
        logic                     sw_te;
        logic [31:0]              param;
        logic [1:0]               sel0;
        logic [1:0]               sel1;
        logic [31:0]              div_cnt;
        logic                     div_q;
        aux_io_pkg::gate_state_t  gate;
        logic                     sw_te_req;
        logic                     te_pulse;
        logic [31:0]              rdata;
        logic                     ack;
        logic [15:0]              smp;
        logic                     smp_v;
    } core_state_t;

    core_state_t st;
    core_state_t next_st;

    logic aux_lvl;
    logic aux_rise;
    logic aux_fall;
    logic aux2_lvl;
    logic trig_lvl;
    logic is_input;
    logic wr_hit;
    logic [31:0] status;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    aux_pin_sync u_aux (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .pin      (aux_in),
        .level    (aux_lvl),
        .rise     (aux_rise),
        .fall     (aux_fall)
    );
    aux_pin_sync u_aux2 (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .pin      (aux2_in),
        .level    (aux2_lvl),
        .rise     (),
        .fall     ()
    );
    aux_pin_sync u_trig (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .pin      (ext_trig_in),
        .level    (trig_lvl),
        .rise     (),
        .fall     ()
    );

    assign is_input = (st.mode == `MODE_TRIG_EN_IN) ||
                      (st.mode == `MODE_LEVEL_IN);
    // a write lands only at the edge where waitrequest is seen low
    assign wr_hit   = avs_write & st.ack;
    assign status   = {29'h0, st.gate == aux_io_pkg::gate_armed,
                       capture_active, aux_lvl};

    always_comb begin
        next_st          = st;
        next_st.ack      = (avs_read | avs_write) & ~st.ack;
        next_st.te_pulse = 1'b0;
        next_st.smp_v    = sample_valid;
        if (wr_hit) begin
            case (avs_address)
                `ADDR_MODE: begin
                    next_st.mode    = avs_writedata[3:0];
                    next_st.sw_te   = avs_writedata[`MODE_SW_TE_BIT];
                    next_st.div_cnt = 32'h0;
                    next_st.div_q   = 1'b0;
                    next_st.gate    = aux_io_pkg::gate_idle;
                end
                `ADDR_PARAM: begin
                    next_st.param   = avs_writedata;
                    next_st.div_cnt = 32'h0;
                end
                `ADDR_LSB_SEL: begin
                    next_st.sel0 = avs_writedata[1:0];
                    next_st.sel1 = avs_writedata[9:8];
                end
                `ADDR_SW_ENABLE: next_st.sw_te_req = avs_writedata[0];
                default: ;
            endcase
        end
        if (avs_read & ~st.ack) begin
            case (avs_address)
                `ADDR_MODE:     next_st.rdata = {23'h0, st.sw_te, 4'h0,
                                                 st.mode};
                `ADDR_PARAM:    next_st.rdata = st.param;
                `ADDR_LSB_SEL:  next_st.rdata = {22'h0, st.sel1, 6'h0,
                                                 st.sel0};
                `ADDR_STATUS:   next_st.rdata = status;
                default:        next_st.rdata = 32'h0;
            endcase
        end
        if (st.mode == `MODE_DIV_CLK && st.param >= `DIV_MIN) begin
            if (st.div_cnt >= st.param - 32'h1) begin
                next_st.div_cnt = 32'h0;
                next_st.div_q   = 1'b1;
            end else begin
                next_st.div_cnt = st.div_cnt + 32'h1;
                if (st.div_cnt + 32'h1 == {1'b0, st.param[31:1]}) begin
                    next_st.div_q = 1'b0;
                end
            end
        end
        if (st.mode == `MODE_TRIG_EN_IN) begin
            next_st.te_pulse = (st.param == `SLOPE_FALLING) ? aux_fall
                                                            : aux_rise;
        end
        case (st.gate)
            aux_io_pkg::gate_idle: begin
                if (st.sw_te && !is_input) begin
                    next_st.gate = aux_io_pkg::gate_armed;
                end
            end
            aux_io_pkg::gate_armed: begin
                if (st.sw_te_req) begin
                    // an enable written in this very cycle outlives the use
                    next_st.sw_te_req = wr_hit && avs_writedata[0] &&
                        avs_address == `ADDR_SW_ENABLE;
                    next_st.gate      = aux_io_pkg::gate_fill;
                end
            end
            aux_io_pkg::gate_fill: begin
                if (buffer_done) begin
                    next_st.gate = aux_io_pkg::gate_armed;
                end
            end
            default: next_st.gate = aux_io_pkg::gate_idle;
        endcase
        if (!st.sw_te || is_input) begin
            next_st.gate = aux_io_pkg::gate_idle;
        end
        next_st.smp = sample_in;
        if (sample_valid) begin
            next_st.smp[0] = pick(st.sel0, sample_in[0]);
            next_st.smp[1] = pick(st.sel1, sample_in[1]);
        end
    end

    function automatic logic pick(input logic [1:0] s, input logic d);
        logic r;
        r = 1'b0;
        case (s)
            `LOW_BIT_EXT_TRIGGER_STATE: r = trig_lvl;
            `LSB_AUX2:     r = aux2_lvl;
            `LSB_AUX1:     r = aux_lvl;
            default:       r = d & (SAMPLE_BITS > 16);
        endcase
        return r;
    endfunction

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st       <= '0;
            st.param <= `PARAM_RESET;
            st.gate  <= aux_io_pkg::gate_idle;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb begin
        case (st.mode)
            `MODE_ACQ_IND: aux_out = capture_active;
            `MODE_DIV_CLK: aux_out = st.div_q;
            `MODE_GP_OUT:  aux_out = st.param[0];
            default:       aux_out = 1'b0;
        endcase
    end
    assign aux_oe_n             = is_input;
    assign avs_waitrequest      = (avs_read | avs_write) & ~st.ack;
    assign avs_readdata         = st.rdata;
    assign trigger_enable_event = st.te_pulse;
    assign trigger_accept       = trigger_in &
        (!st.sw_te || is_input || st.gate == aux_io_pkg::gate_fill);
    assign sample_out           = st.smp;
    assign sample_out_valid     = st.smp_v;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_acq_ind: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        st.mode == `MODE_ACQ_IND |-> aux_out == capture_active)
        else $error("indicator mismatch");
    chk_te_edge: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        st.mode == `MODE_TRIG_EN_IN && st.param != `SLOPE_FALLING && aux_rise
        && $stable(st.mode) |=> trigger_enable_event)
        else $error("missed enable edge");
    chk_div_wrap: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        st.mode == `MODE_DIV_CLK |-> st.div_cnt < st.param
        || st.param < `DIV_MIN)
        else $error("divider overran");
    chk_gp_level: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        st.mode == `MODE_GP_OUT |-> aux_out == st.param[0] && !aux_oe_n)
        else $error("static level wrong");
    chk_input_hiz: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        st.mode == `MODE_LEVEL_IN |-> aux_oe_n && status[0] == aux_lvl)
        else $error("input mode drives pin");
    chk_gate_block: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        st.sw_te && !is_input && st.gate != aux_io_pkg::gate_fill
        |-> !trigger_accept)
        else $error("trigger passed closed gate");
    chk_busy_bit: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        avs_read && !st.ack && avs_address == `ADDR_STATUS
        |=> avs_readdata[1] == $past(capture_active))
        else $error("busy bit wrong");
    chk_lsb_zero: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        sample_valid && st.sel0 == `LSB_ZERO && st.sel1 == `LSB_ZERO
        && $stable(st.sel0) |=> sample_out[1:0] == 2'h0)
        else $error("low bits not zero");
    chk_lsb_trig: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        sample_valid && st.sel0 == `LOW_BIT_EXT_TRIGGER_STATE
        |=> sample_out[0] == $past(trig_lvl))
        else $error("trigger bit not injected");
endmodule
`default_nettype wire

// ===== testbench/aux_partner.sv
// far-side equipment on the auxiliary connector
// assumes one core clock; the pin level is resolved from the device enable
`timescale 1ns/1ps
`default_nettype none
module aux_partner (
    input  wire logic core_clk,
    input  wire logic aux_out,
    input  wire logic aux_oe_n,
    input  wire logic drive_lvl,
    output logic      pin,
    output logic      aux2,
    output logic      ext_trig,
    output int        rises
);
    logic last  = 1'b0;
    int   count = 0;
    // the device owns the wire whenever its driver is enabled
    assign pin      = aux_oe_n ? drive_lvl : aux_out;
    // opposite levels on the side inputs so a swapped source shows up
    assign aux2     = ~drive_lvl;
    assign ext_trig = drive_lvl;
    assign rises    = count;
    always @(posedge core_clk) begin
        last <= pin;
        if (pin && !last) count <= count + 1;
    end
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// bench for the auxiliary connector selector and low-bit injection
// assumes the partner model on the pin and Avalon-MM register access
`include "aux_io_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        core_clk       = 1'b0;
    logic        sys_rst        = 1'b1;
    logic [3:0]  avs_address    = 4'h0;
    logic        avs_read       = 1'b0;
    logic        avs_write      = 1'b0;
    logic [31:0] avs_writedata  = 32'h0;
    logic [31:0] avs_readdata;
    logic [31:0] rdv;
    logic        avs_waitrequest, aux_in, aux_out, aux_oe_n;
    logic        aux2_in, ext_trig_in, trigger_accept;
    logic        capture_active = 1'b0;
    logic        trigger_in     = 1'b0;
    logic        buffer_done    = 1'b0;
    logic        drive_lvl      = 1'b0;
    logic        sample_valid   = 1'b1;
    logic [15:0] sample_in      = 16'hABC0;
    logic [15:0] sample_out;
    logic        trigger_enable_event, sample_out_valid;
    logic [3:0]  v              = 4'hA;
    int          failures       = 0;
    int          cmp_count      = 0;
    int          events         = 0;
    int          rises, r0;

    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (trigger_enable_event === 1'b1) events <= events + 1;
    end

    aux_io_lsb dut (.core_clk, .sys_rst, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .aux_in, .aux_out, .aux_oe_n, .aux2_in, .ext_trig_in,
        .capture_active, .trigger_in, .buffer_done, .trigger_accept,
        .trigger_enable_event, .sample_in, .sample_valid, .sample_out,
        .sample_out_valid);
    aux_partner far (.core_clk, .aux_out, .aux_oe_n, .drive_lvl,
        .pin(aux_in), .aux2(aux2_in), .ext_trig(ext_trig_in), .rises);

    task end_sim;
        if (failures == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
        cmp_count++;
        if (seen !== e) begin
            failures++;
            $display("BAD %s exp %h seen %h", nm, e, seen);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // waitrequest is taken as it stood at the edge; the write lands there too
    task bus(input logic rw, input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !rw;
        avs_write     <= rw;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        rdv = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rd(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk("readdata", rdv, e);
    endtask

    initial begin
        cyc(10);
        sys_rst <= 1'b0;
        rd(`ADDR_MODE, 32'h0);
        rd(`ADDR_PARAM, `PARAM_RESET);
        rd(4'hF, 32'h0);
        capture_active <= 1'b1;
        cyc(4);
        chk("aux_out", aux_out, 1);
        rd(`ADDR_STATUS, 32'h3);
        capture_active <= 1'b0;
        cyc(4);
        chk("aux_out", aux_out, 0);
        rd(`ADDR_STATUS, 32'h0);
        wr(`ADDR_MODE, `MODE_GP_OUT);
        for (int i = 0; i < 2; i++) begin
            wr(`ADDR_PARAM, i);
            cyc(1);
            chk("aux_out", aux_out, i);
        end
        wr(`ADDR_MODE, `MODE_DIV_CLK);
        wr(`ADDR_PARAM, 32'h4);
        cyc(4);
        r0 = rises;
        cyc(80);
        chk("pacer rises", rises - r0, 20);
        wr(`ADDR_MODE, `MODE_LEVEL_IN);
        drive_lvl <= 1'b1;
        cyc(4);
        chk("aux_oe_n", aux_oe_n, 1);
        rd(`ADDR_STATUS, 32'h1);
        // pin 1, aux2 0, ext 1, zero fill 0 give source table v
        for (int c = 0; c < 4; c++) begin
            wr(`ADDR_LSB_SEL, ((3 - c) << 8) | c);
            cyc(2);
            chk("sample", sample_out, {14'h2AF0, v[3-c], v[c]});
            chk("sample_valid", sample_out_valid, 1);
        end
        wr(`ADDR_PARAM, `SLOPE_RISING);
        wr(`ADDR_MODE, `MODE_TRIG_EN_IN);
        drive_lvl <= 1'b0;
        cyc(6);
        r0 = events;
        drive_lvl <= 1'b1;
        cyc(6);
        chk("enable events", events - r0, 1);
        drive_lvl <= 1'b0;
        cyc(6);
        chk("enable events", events - r0, 1);
        wr(`ADDR_PARAM, `SLOPE_FALLING);
        r0 = events;
        drive_lvl <= 1'b1;
        cyc(6);
        chk("enable events", events - r0, 0);
        drive_lvl <= 1'b0;
        cyc(6);
        chk("enable events", events - r0, 1);
        wr(`ADDR_MODE, 32'h1 << `MODE_SW_TE_BIT);
        trigger_in <= 1'b1;
        cyc(3);
        chk("trigger_accept", trigger_accept, 0);
        rd(`ADDR_STATUS, 32'h4);
        wr(`ADDR_SW_ENABLE, 32'h1);
        cyc(2);
        chk("trigger_accept", trigger_accept, 1);
        buffer_done <= 1'b1;
        cyc(1);
        buffer_done <= 1'b0;
        cyc(2);
        chk("trigger_accept", trigger_accept, 0);
        end_sim;
    end
    // the sequence needs well under a thousand cycles
    initial begin
        cyc(20000);
        failures++;
        end_sim;
    end
endmodule
`default_nettype wire
